//--- epvid_ctrl.sv
// Host controller that reads the identification bytes and verifies locations
// of a 4k x 8 EPROM through its address, chip select and output enable pins.
// Assumes an external driver turns idModeHv into the raised identification
// voltage on the id mode address line, and that programming is done elsewhere.
// Contract
// - Verify: chip select and enable low
// - Sample only after output delay elapses
// - Raised id line, other addresses low
// - Read id before allowing any programming
`timescale 1ns/1ps
`include "epvid_regs.svh"
module epvid_ctrl #(
    parameter int ADDR_W = `EPV_ADDR_W,
    parameter int TOV_NS = `EPV_TOV_NS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Command
    input wire logic cmdValid,
    input wire logic cmdId,
    input wire logic [ADDR_W-1:0] cmdAddr,
    input wire logic [`EPV_DATA_W-1:0] cmdExpect,
    output logic cmdReady,
    // Result
    output logic rspValid,
    output logic [`EPV_DATA_W-1:0] rspData,
    output logic rspMatch,
    output logic rspBlank,
    output logic idValid,
    output logic [`EPV_DATA_W-1:0] idMaker,
    output logic [`EPV_DATA_W-1:0] idDevice,
    // Device pins
    output logic [ADDR_W-1:0] romAddr,
    output logic ceN,
    output logic oeN,
    output logic idModeHv,
    input wire logic [`EPV_DATA_W-1:0] dataOutLines
);
    import epvid_pkg::*;

    localparam int TOV_CYC = (TOV_NS + `EPV_CLK_NS - 1) / `EPV_CLK_NS;
    localparam logic [`EPV_CNT_W-1:0] SETUP_CNT = `EPV_CNT_W'(`EPV_SETUP_CYC - 1);
    localparam logic [`EPV_CNT_W-1:0] WAIT_CNT = `EPV_CNT_W'(TOV_CYC + `EPV_SYNC_LAT - 1);

    epvid_state_t state_r;
    logic [`EPV_CNT_W-1:0] cnt_r;
    logic autoId_r;
    logic isId_r;
    logic idPhase_r;
    logic [`EPV_DATA_W-1:0] expect_r;
    logic cmdReady_r;
    logic rspValid_r;
    logic [`EPV_DATA_W-1:0] rspData_r;
    logic rspMatch_r;
    logic rspBlank_r;
    logic idValid_r;
    logic [`EPV_DATA_W-1:0] idMaker_r;
    logic [`EPV_DATA_W-1:0] idDevice_r;
    logic [ADDR_W-1:0] romAddr_r;
    logic ceN_r;
    logic oeN_r;
    logic idModeHv_r;
    logic [`EPV_DATA_W-1:0] dataSync;
    logic dataStable;
    logic take;
    logic capture;

    function automatic logic [ADDR_W-1:0] idAddr(input logic devByte);
        idAddr = devByte ? ADDR_W'(`EPV_ID_ADDR_DEVICE) : ADDR_W'(`EPV_ID_ADDR_MAKER);
    endfunction

    epvid_sync #(.W(`EPV_DATA_W)) dataSyncU (
        .clk(clk),
        .rstn(rstn),
        .pinIn(dataOutLines),
        .syncOut(dataSync),
        .stable(dataStable)
    );

    assign take = cmdValid && cmdReady_r;
    // data read only with both low
    assign capture = (state_r == EPVID_SAMPLE) && !ceN_r && !oeN_r && dataStable;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= EPVID_IDLE;
            cnt_r <= '0;
            autoId_r <= 1'b1;
            isId_r <= 1'b0;
            idPhase_r <= 1'b0;
            expect_r <= '0;
            cmdReady_r <= 1'b0;
            romAddr_r <= '0;
            ceN_r <= 1'b1;
            oeN_r <= 1'b1;
            idModeHv_r <= 1'b0;
        end else begin
            case (state_r)
                EPVID_IDLE: begin
                    ceN_r <= 1'b1;
                    oeN_r <= 1'b1;
                    cnt_r <= SETUP_CNT;
                    if (autoId_r || (take && cmdId)) begin
                        autoId_r <= 1'b0;
                        isId_r <= 1'b1;
                        idPhase_r <= 1'b0;
                        romAddr_r <= idAddr(1'b0);
                        idModeHv_r <= 1'b1;
                        cmdReady_r <= 1'b0;
                        state_r <= EPVID_SETUP;
                    end else if (take) begin
                        isId_r <= 1'b0;
                        expect_r <= cmdExpect;
                        romAddr_r <= cmdAddr;
                        idModeHv_r <= 1'b0;
                        cmdReady_r <= 1'b0;
                        state_r <= EPVID_SETUP;
                    end else begin
                        idModeHv_r <= 1'b0;
                        cmdReady_r <= idValid_r;
                    end
                end
                EPVID_SETUP: begin
                    if (cnt_r == '0) begin
                        ceN_r <= 1'b0;
                        oeN_r <= 1'b0;
                        cnt_r <= WAIT_CNT;
                        state_r <= EPVID_STROBE;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                EPVID_STROBE: begin
                    if (cnt_r == '0) begin
                        state_r <= EPVID_SAMPLE;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                EPVID_SAMPLE: begin
                    if (capture) begin
                        ceN_r <= 1'b1;
                        oeN_r <= 1'b1;
                        cnt_r <= SETUP_CNT;
                        if (isId_r && !idPhase_r) begin
                            idPhase_r <= 1'b1;
                            romAddr_r <= idAddr(1'b1);
                            state_r <= EPVID_SETUP;
                        end else begin
                            state_r <= EPVID_IDLE;
                        end
                    end
                end
                default: begin
                    state_r <= EPVID_IDLE;
                    ceN_r <= 1'b1;
                    oeN_r <= 1'b1;
                    idModeHv_r <= 1'b0;
                end
            endcase
        end
    end

    // Results and identification store
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rspValid_r <= 1'b0;
            rspData_r <= '0;
            rspMatch_r <= 1'b0;
            rspBlank_r <= 1'b0;
            idValid_r <= 1'b0;
            idMaker_r <= '0;
            idDevice_r <= '0;
        end else begin
            rspValid_r <= capture && !isId_r;
            if (take && cmdId) begin
                idValid_r <= 1'b0;
            end
            if (capture && isId_r) begin
                if (!idPhase_r) begin
                    idMaker_r <= dataSync;
                end else begin
                    idDevice_r <= dataSync;
                    idValid_r <= 1'b1;
                end
            end
            if (capture && !isId_r) begin
                rspData_r <= dataSync;
                rspMatch_r <= (dataSync == expect_r);
                rspBlank_r <= (dataSync == {`EPV_DATA_W{1'b1}});
            end
        end
    end

    assign cmdReady = cmdReady_r;
    assign rspValid = rspValid_r;
    assign rspData = rspData_r;
    assign rspMatch = rspMatch_r;
    assign rspBlank = rspBlank_r;
    assign idValid = idValid_r;
    assign idMaker = idMaker_r;
    assign idDevice = idDevice_r;
    assign romAddr = romAddr_r;
    assign ceN = ceN_r;
    assign oeN = oeN_r;
    assign idModeHv = idModeHv_r;

    // Cycles spent with chip select low, for the delay check
    logic [7:0] lowCnt_r;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lowCnt_r <= '0;
        end else if (ceN_r) begin
            lowCnt_r <= '0;
        end else if (lowCnt_r != 8'hFF) begin
            lowCnt_r <= lowCnt_r + 8'h01;
        end
    end

    sequence idFirstByte;
        capture && isId_r && !idPhase_r;
    endsequence
    sequence idSecondByte;
        capture && isId_r && idPhase_r;
    endsequence

    verify_pins_a: assert property (@(posedge clk) disable iff (!rstn)
        (state_r == EPVID_STROBE) |-> (!ceN_r && !oeN_r))
        else $error("verify strobe without both controls low");
    sample_delay_a: assert property (@(posedge clk) disable iff (!rstn)
        capture |-> (lowCnt_r >= 8'(TOV_CYC + `EPV_SYNC_LAT)))
        else $error("data sampled before output delay");
    id_pins_a: assert property (@(posedge clk) disable iff (!rstn)
        (idModeHv_r && !ceN_r) |-> (romAddr_r[ADDR_W-1:1] == '0 && !oeN_r))
        else $error("id mode with other address lines not low");
    id_select_a: assert property (@(posedge clk) disable iff (!rstn)
        capture && isId_r |-> (romAddr_r[`EPV_SEL_BIT] == idPhase_r))
        else $error("id byte select line wrong");
    id_sequence_a: assert property (@(posedge clk) disable iff (!rstn)
        idFirstByte ##[1:40] idSecondByte |=> (idValid_r && idDevice_r == $past(dataSync)))
        else $error("device byte not stored after second read");
    id_first_a: assert property (@(posedge clk) disable iff (!rstn)
        cmdReady_r |-> idValid_r)
        else $error("command accepted before id read");
    deselect_after_a: assert property (@(posedge clk) disable iff (!rstn)
        capture |=> (ceN_r && oeN_r) [*2])
        else $error("chip select not released after sample");
    array_read_a: assert property (@(posedge clk) disable iff (!rstn)
        (!ceN_r && !isId_r) |-> !idModeHv_r)
        else $error("raised id line during array read");
    match_flag_a: assert property (@(posedge clk) disable iff (!rstn)
        rspValid_r |-> (rspMatch_r == (rspData_r == expect_r)))
        else $error("verify match flag wrong");

endmodule

//--- epvid_regs.svh
// Timing and field constants for the EPROM verify and identification host.
// Assumes a 10 MHz system clock; included by bare name.
`ifndef EPVID_REGS_SVH
`define EPVID_REGS_SVH

`define EPV_ADDR_W 12
`define EPV_DATA_W 8
`define EPV_CLK_NS 100
// Output delay from chip select low to valid data, in ns (plain default)
`define EPV_TOV_NS 250
// Cycles of stable address and raised line before chip select falls
`define EPV_SETUP_CYC 2
// Latency of the three-stage input synchroniser
`define EPV_SYNC_LAT 3
// Address bit that carries the raised identification voltage
`define EPV_ID_LINE_BIT 9
// Address bit that picks maker byte or device byte
`define EPV_SEL_BIT 0
// Identification readout addresses: maker byte, then device byte
`define EPV_ID_ADDR_MAKER 12'h000
`define EPV_ID_ADDR_DEVICE 12'h001
`define EPV_CNT_W 4

`endif

//--- epvid_pkg.sv
// Types for the EPROM verify and identification host.
// Constants live in epvid_regs.svh.
package epvid_pkg;

    typedef enum logic [3:0] {
        EPVID_IDLE   = 4'h1,
        EPVID_SETUP  = 4'h2,
        EPVID_STROBE = 4'h4,
        EPVID_SAMPLE = 4'h8
    } epvid_state_t;

endpackage

//--- epvid_sync.sv
// Three-flop synchroniser for the EPROM data pins.
// Assumes the pins are asynchronous to clk; stable flags two later stages agreeing.
`timescale 1ns/1ps
module epvid_sync #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Raw pins and synchronised view
    input wire logic [W-1:0] pinIn,
    output logic [W-1:0] syncOut,
    output logic stable
);

    logic [W-1:0] ff1_r;
    logic [W-1:0] ff2_r;
    logic [W-1:0] ff3_r;
    logic stable_r;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ff1_r <= '0;
            ff2_r <= '0;
            ff3_r <= '0;
        end else begin
            ff1_r <= pinIn;
            ff2_r <= ff1_r;
            ff3_r <= ff2_r;
        end
    end

    // Agreement is registered so the flag lines up with syncOut one cycle on
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stable_r <= 1'b0;
        end else begin
            stable_r <= (ff2_r == ff3_r);
        end
    end

    assign syncOut = ff3_r;
    assign stable = stable_r;

endmodule

//--- epvid_rom_model.sv
// Behavioural model of the 4k x 8 EPROM seen by the verify and id host.
// Assumes a raised id line is signalled by idModeHv; no pull on the data lines.
`timescale 1ns/1ps
module epvid_rom_model #(
    // Arbitrary identification values
    parameter logic [7:0] MAKER_CODE = 8'hA5,
    parameter logic [7:0] DEVICE_CODE = 8'h3C
) (
    // Device pins
    input wire logic [11:0] romAddr,
    input wire logic ceN,
    input wire logic oeN,
    input wire logic idModeHv,
    output logic [7:0] dataOut
);
    logic [7:0] mem [0:4095];
    logic [7:0] lastR;
    logic [7:0] drv;
    logic ready;
    int delayNs = 150;

    initial begin
        for (int i = 0; i < 4096; i++) begin
            mem[i] = 8'hFF;
        end
        lastR = 8'h00;
        ready = 1'b0;
    end

    task automatic burn(input logic [11:0] a, input logic [7:0] v);
        mem[a] = mem[a] & v;
    endtask

    always @(negedge ceN) begin
        ready = 1'b0;
        #(delayNs);
        if (ceN === 1'b0) begin
            ready = 1'b1;
        end
    end

    always @(posedge ceN) begin
        ready = 1'b0;
        lastR = drv;
    end

    always @(*) begin
        if (idModeHv !== 1'b1) begin
            drv = mem[romAddr];
        end else if (romAddr[11:1] == 11'h000) begin
            drv = romAddr[0] ? DEVICE_CODE : MAKER_CODE;
        end else begin
            drv = ~lastR;
        end
    end

    // released lines show junk, not the last byte
    assign dataOut = (!ceN && !oeN && ready) ? drv : ~lastR;
endmodule

//--- tb.sv
// Self-checking bench for epvid_ctrl against the EPROM model.
// Assumes the 10 MHz clock and default timing parameters of the host.
`timescale 1ns/1ps
module tb;
    logic clk, rstn, cmdValid, cmdId, cmdReady, rspValid, rspMatch, rspBlank;
    logic idValid, ceN, oeN, idModeHv, idPrev;
    logic [11:0] cmdAddr, romAddr, a;
    logic [7:0] cmdExpect, rspData, idMaker, idDevice, dataOutLines, d, x;
    logic [16:0] expQ[$];
    logic [16:0] e;
    logic [31:0] r;
    logic [31:0] seed = 32'hBD13;
    int fail_count = 0;
    int num_checks = 0;
    // Arbitrary identification values
    localparam logic [7:0] MK = 8'hA5;
    localparam logic [7:0] DV = 8'h3C;

    epvid_ctrl i_dut(.clk(clk), .rstn(rstn), .cmdValid(cmdValid), .cmdId(cmdId),
        .cmdAddr(cmdAddr), .cmdExpect(cmdExpect), .cmdReady(cmdReady),
        .rspValid(rspValid), .rspData(rspData), .rspMatch(rspMatch), .rspBlank(rspBlank),
        .idValid(idValid), .idMaker(idMaker), .idDevice(idDevice), .romAddr(romAddr),
        .ceN(ceN), .oeN(oeN), .idModeHv(idModeHv), .dataOutLines(dataOutLines));
    epvid_rom_model #(.MAKER_CODE(MK), .DEVICE_CODE(DV)) i_rom(.romAddr(romAddr),
        .ceN(ceN), .oeN(oeN), .idModeHv(idModeHv), .dataOut(dataOutLines));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input string n, input logic [16:0] ex, input logic [16:0] got);
        num_checks++;
        if (ex !== got) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, ex, got);
        end
    endtask

    // Results are taken off the queue as they appear
    always @(negedge clk) begin
        if (rspValid === 1'b1) begin
            e = expQ.pop_front();
            chk("verify", e, {1'b0, rspData, 6'h00, rspMatch, rspBlank});
        end
        if (idValid === 1'b1 && idPrev !== 1'b1) begin
            e = expQ.pop_front();
            chk("id", e, {1'b1, idMaker, idDevice});
        end
        idPrev = idValid;
        if (cmdReady === 1'b1) chk("ready", 17'h1, {16'h0, idValid});
        if (ceN === 1'b0) chk("pins", 17'h0, {5'h0, oeN, idModeHv ? romAddr[11:1] : 11'h0});
    end

    // Results are awaited at the falling edge; control returns just after a rising edge
    task automatic drain();
        int n = 0;
        while (expQ.size() != 0 && n < 400) begin
            @(negedge clk);
            n++;
        end
        if (n >= 400) chk("drain", 17'h0, 17'(expQ.size()));
        @(posedge clk);
        #1;
    endtask

    task automatic cmd(input logic id, input logic [11:0] ad, input logic [7:0] ex,
                       input logic [16:0] res);
        int n = 0;
        cmdValid = 1'b1;
        cmdId = id;
        cmdAddr = ad;
        cmdExpect = ex;
        // Ready is a registered output, so it is settled at the falling edge
        do begin
            @(negedge clk);
            n++;
        end while (cmdReady !== 1'b1 && n < 400);
        expQ.push_back(res);
        @(posedge clk);
        #1;
        cmdValid = 1'b0;
        drain();
    endtask

    task automatic ver(input logic [11:0] ad, input logic [7:0] dat, input logic [7:0] ex);
        cmd(1'b0, ad, ex, {1'b0, dat, 6'h00, dat == ex, dat == 8'hFF});
    endtask

    task automatic doReset();
        rstn = 1'b0;
        expQ.delete();
        repeat (12) @(posedge clk);
        #1;
        rstn = 1'b1;
        expQ.push_back({1'b1, MK, DV});
        drain();
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        #(30000 * 100);
        fail_count++;
        $display("BAD watchdog expected done seen hang");
        results();
    end

    initial begin
        {cmdValid, cmdId, cmdAddr, cmdExpect, idPrev} = '0;
        doReset();
        $display("test auto id done");
        for (int i = 0; i < 12; i++) begin
            r = xs();
            a = {r[6:0], 1'b1, 4'(i)};
            r = xs();
            d = r[7:0];
            r = xs();
            x = r[0] ? d : d ^ 8'h10;
            i_rom.burn(a, d);
            ver(a, d, x);
        end
        $display("test random verify done");
        ver(12'hFFF, 8'hFF, 8'hFF);
        ver(12'h000, 8'hFF, 8'h00);
        i_rom.burn(12'h001, 8'h5A);
        ver(12'h001, 8'h5A, 8'h5A);
        i_rom.burn(12'h801, 8'hF0);
        i_rom.burn(12'h801, 8'h3C);
        ver(12'h801, 8'h30, 8'h30);
        $display("test erased and clear done");
        i_rom.delayNs = 250;
        ver(12'h001, 8'h5A, 8'h00);
        cmd(1'b1, 12'h000, 8'h00, {1'b1, MK, DV});
        ver(12'h801, 8'h30, 8'h30);
        $display("test slow and id reread done");
        doReset();
        ver(12'h001, 8'h5A, 8'h5A);
        $display("test second reset done");
        results();
    end
endmodule
